// File: common/dinirq_pkg.sv
package dinirq_pkg;
	localparam int CHANNELS = 16;
	localparam logic [15:0] PATTERN_RST = 16'h0000;
	localparam logic [15:0] MASK_RST = 16'h0000;
	localparam int SYNC_STAGES = 2;
	localparam int STAT_INTR_BIT = 9;
	localparam int STAT_SRQ_BIT = 6;
	localparam logic [1:0] SRC_INTERNAL = 2'h0;
	localparam logic [1:0] SRC_EXTERNAL = 2'h1;
	localparam logic [1:0] SRC_BACKPLANE = 2'h2;
	typedef enum logic {equal_match_mode, unequal_match_mode} dinirq_mode_t;
	typedef enum logic {accept_all, accept_first} dinirq_acc_t;
	function automatic logic dinirq_match(input logic [15:0] st, input logic [15:0] pat,
			input logic [15:0] msk, input dinirq_mode_t md);
		logic eq;
		eq = ((st ^ pat) & msk) == 16'h0000;
		return (md == equal_match_mode) ? eq : !eq;
	endfunction : dinirq_match
endpackage : dinirq_pkg

// File: design/dinirq_status.sv
`timescale 1ns/10ps
module dinirq_status (
	input wire logic clock_i, // clock
	input wire logic rstn_i, // async reset
	input wire logic irq_i, // accessory irq level
	input wire logic sys_sense_i, // mainframe senses irq
	input wire logic rqs_en_i, // service requests enabled
	input wire logic status_query_i, // status query pulse
	input wire logic serial_poll_read_i, // serial poll pulse
	output logic intr_stat_o, // status bit 9
	output logic srq_stat_o, // status bit 6
	output logic srq_o // service request line
);
	logic seen_r;
	logic take;
	// new irq recognised only with both bits clear
	assign take = irq_i && sys_sense_i && !seen_r && !intr_stat_o && !srq_stat_o;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) seen_r <= 1'b0;
		else seen_r <= irq_i && sys_sense_i;
	end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			intr_stat_o <= 1'b0;
			srq_stat_o <= 1'b0;
		end else begin
			if (take) intr_stat_o <= 1'b1;
			else if (status_query_i) intr_stat_o <= 1'b0;
			if (take && rqs_en_i) srq_stat_o <= 1'b1;
			else if (serial_poll_read_i) srq_stat_o <= 1'b0;
		end
	end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) srq_o <= 1'b0;
		else srq_o <= (take && rqs_en_i) || (srq_stat_o && !serial_poll_read_i);
	end
endmodule : dinirq_status

// File: design/dinirq_sync.sv
`timescale 1ns/10ps
module dinirq_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic clock_i, // clock
	input wire logic rstn_i, // async reset
	input wire logic [WIDTH-1:0] d_i, // async input
	output logic [WIDTH-1:0] q_o // synchronised
);
	logic [WIDTH-1:0] meta_r;
	initial begin
		if (WIDTH < 1) $error("width must be positive");
	end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// reset to the pin's idle level so no false edge follows release
			meta_r <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_o <= meta_r;
		end
	end
endmodule : dinirq_sync

// File: design/dinirq_top.sv
`timescale 1ns/10ps
module dinirq_top #(
	parameter int CH = dinirq_pkg::CHANNELS
) (
	input wire logic clock_i, // 125 MHz clock
	input wire logic rstn_i, // async reset, active low
	input wire logic [CH-1:0] chan_i, // input channel pins
	input wire logic first_stage_trigger_input_i, // external trigger pin
	input wire logic int_first_trig_i, // internal first-stage trigger pulse
	input wire logic second_trig_i, // second-stage trigger pulse
	input wire logic self_test_i, // self-test ran pulse
	input wire logic first_src_ext_i, // first-stage source is external pin
	input wire logic [15:0] addr_i, // register address
	input wire logic [15:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [15:0] rdata_o, // read data, next cycle
	input wire logic service_i, // mainframe services match irq
	input wire logic sys_sense_i, // mainframe sensing enabled
	input wire logic rqs_en_i, // service requests enabled
	input wire logic status_query_i, // status query pulse
	input wire logic serial_poll_read_i, // serial poll pulse
	output logic irq_o, // accessory interrupt request
	output logic refused_o, // last setting refused
	output logic [15:0] capture_o, // first-rank input register
	output logic intr_stat_o, // mainframe status bit 9
	output logic srq_stat_o, // mainframe status bit 6
	output logic srq_o // service request line
);
	import dinirq_pkg::*;

	localparam logic [15:0] A_PATTERN = 16'h0000;
	localparam logic [15:0] A_MASK = 16'h0001;
	localparam logic [15:0] A_CTRL = 16'h0002;
	localparam logic [15:0] A_CMD = 16'h0003;
	localparam logic [15:0] A_STATUS = 16'h0004;
	localparam logic [15:0] A_CAPTURE = 16'h0005;
	// command word bits
	localparam int C_ENABLE = 0;
	localparam int C_DISABLE = 1;
	localparam int C_SEL_MATCH = 2;
	localparam int C_SEL_CAPT = 3;

	initial begin
		if (CH != 16) $error("block serves exactly 16 channels");
	end

	logic [CH-1:0] chan_s;
	logic trig_s;
	logic trig_d_r;
	logic ext_fall;
	logic first_trig;
	logic [15:0] pattern_r;
	logic [15:0] mask_r;
	dinirq_mode_t mode_r;
	dinirq_acc_t acc_r;
	logic [1:0] src_r;
	logic match_en_r;
	logic capt_en_r;
	logic match_pend_r;
	logic capt_pend_r;
	logic armed_r;
	logic tested_r;
	logic outstanding_r;
	logic valid_trig;
	logic cmd_wr;
	logic ctrl_wr;
	logic en_match;
	logic en_capt;
	logic want_capt;
	logic capt_ok;
	logic src_ok;
	logic [1:0] src_new;
	logic disable_match;
	logic hit;

	dinirq_sync #(.WIDTH(CH)) u_chan_sync (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.d_i(chan_i),
		.q_o(chan_s)
	);
	dinirq_sync #(.WIDTH(1), .RST_VAL(1'b1)) u_trig_sync (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.d_i(first_stage_trigger_input_i),
		.q_o(trig_s)
	);

	// idle high, so a pin already low at release reads as a falling edge
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) trig_d_r <= 1'b1;
		else trig_d_r <= trig_s;
	end
	assign ext_fall = trig_d_r && !trig_s;
	assign first_trig = first_src_ext_i ? ext_fall : int_first_trig_i;

	assign valid_trig = first_trig && (acc_r == accept_all || armed_r);

	assign cmd_wr = wr_i && addr_i == A_CMD;
	assign ctrl_wr = wr_i && addr_i == A_CTRL;
	assign en_match = cmd_wr && wdata_i[C_ENABLE] && wdata_i[C_SEL_MATCH];
	assign want_capt = cmd_wr && wdata_i[C_ENABLE] && wdata_i[C_SEL_CAPT];
	// refuse unless the source is internal
	assign capt_ok = src_r == SRC_INTERNAL;
	assign en_capt = want_capt && capt_ok;
	assign src_new = wdata_i[3:2];
	assign src_ok = !(capt_en_r && src_new != SRC_INTERNAL);
	assign disable_match = (cmd_wr && wdata_i[C_DISABLE] && wdata_i[C_SEL_MATCH]) || service_i;

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pattern_r <= PATTERN_RST;
			mask_r <= MASK_RST;
		end else begin
			if (wr_i && addr_i == A_PATTERN) pattern_r <= wdata_i;
			if (wr_i && addr_i == A_MASK) mask_r <= wdata_i;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			mode_r <= equal_match_mode;
			acc_r <= accept_all;
			src_r <= SRC_INTERNAL;
		end else if (ctrl_wr) begin
			mode_r <= wdata_i[0] ? unequal_match_mode : equal_match_mode;
			acc_r <= wdata_i[1] ? accept_first : accept_all;
			// source change refused while capture enabled
			if (src_ok) src_r <= src_new;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) refused_o <= 1'b0;
		else if (want_capt) refused_o <= !capt_ok;
		else if (ctrl_wr) refused_o <= !src_ok;
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) match_en_r <= 1'b0;
		else if (en_match) match_en_r <= 1'b1;
		else if (disable_match) match_en_r <= 1'b0;
	end

	assign hit = match_en_r && dinirq_match(chan_s, pattern_r, mask_r, mode_r);

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) match_pend_r <= 1'b0;
		else if (en_match) match_pend_r <= 1'b0;
		else if (disable_match) match_pend_r <= 1'b0;
		else if (hit) match_pend_r <= 1'b1;
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) capt_en_r <= 1'b0;
		else if (en_capt) capt_en_r <= 1'b1;
		else if (cmd_wr && wdata_i[C_DISABLE] && wdata_i[C_SEL_CAPT]) capt_en_r <= 1'b0;
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) armed_r <= 1'b1;
		else if (second_trig_i) armed_r <= 1'b1;
		else if (first_trig) armed_r <= 1'b0;
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tested_r <= 1'b0;
			outstanding_r <= 1'b0;
		end else begin
			if (self_test_i) tested_r <= 1'b1;
			else if (en_capt) tested_r <= 1'b0;
			if (valid_trig) outstanding_r <= 1'b1;
			else if (second_trig_i) outstanding_r <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) capture_o <= 16'h0000;
		else if (valid_trig) capture_o <= chan_s;
	end

	// set on valid trigger; set wins over clear
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) capt_pend_r <= 1'b0;
		else if (valid_trig) capt_pend_r <= 1'b1;
		else if (en_capt && (tested_r || self_test_i || outstanding_r)) capt_pend_r <= 1'b1;
		else if (second_trig_i) capt_pend_r <= 1'b0;
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) irq_o <= 1'b0;
		else irq_o <= (match_pend_r && match_en_r) || (capt_pend_r && capt_en_r);
	end

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) rdata_o <= 16'h0000;
		else if (rd_i) begin
			unique case (addr_i)
				A_PATTERN: rdata_o <= pattern_r;
				A_MASK: rdata_o <= mask_r;
				A_CTRL: rdata_o <= {12'h000, src_r, acc_r == accept_first,
						mode_r == unequal_match_mode};
				A_STATUS: rdata_o <= {10'h000, refused_o, armed_r, capt_pend_r,
						match_pend_r, capt_en_r, match_en_r};
				A_CAPTURE: rdata_o <= capture_o;
				default: rdata_o <= 16'h0000;
			endcase
		end else rdata_o <= 16'h0000;
	end

	// mainframe status bits and request line
	dinirq_status u_status (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.irq_i(irq_o),
		.sys_sense_i(sys_sense_i),
		.rqs_en_i(rqs_en_i),
		.status_query_i(status_query_i),
		.serial_poll_read_i(serial_poll_read_i),
		.intr_stat_o(intr_stat_o),
		.srq_stat_o(srq_stat_o),
		.srq_o(srq_o)
	);
endmodule : dinirq_top

// File: verification/dinirq_mainframe.sv
`timescale 1ns/10ps
module dinirq_mainframe (
	input wire logic clock_i, // clock
	input wire logic rstn_i, // reset
	input wire logic irq_i, // accessory irq
	input wire logic srq_i, // srq line
	input wire logic svc_en_i, // service match irq
	input wire logic [3:0] wait_i, // reply delay, nonzero
	output logic service_o, // service pulse
	output logic status_query_o, // query pulse
	output logic serial_poll_read_o // poll pulse
);
	logic [3:0] cnt_r;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_r <= 4'h0;
			status_query_o <= 1'b0;
			serial_poll_read_o <= 1'b0;
		end else begin
			status_query_o <= cnt_r == 4'h1;
			serial_poll_read_o <= status_query_o;
			if (cnt_r != 4'h0)
				cnt_r <= cnt_r - 4'h1;
			else if (srq_i && !status_query_o && !serial_poll_read_o)
				cnt_r <= wait_i;
		end
	end
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i)
			service_o <= 1'b0;
		else
			service_o <= svc_en_i && irq_i && !service_o;
	end
endmodule : dinirq_mainframe

// File: verification/dinirq_props.sv
`timescale 1ns/10ps
module dinirq_props (
	input wire logic clock_i, // clock
	input wire logic rstn_i, // reset
	input wire logic int_first_trig_i, // trigger
	input wire logic first_src_ext_i, // pin source
	input wire logic [15:0] capture_o, // capture word
	input wire logic irq_o, // irq level
	input wire logic sys_sense_i, // sensing on
	input wire logic rqs_en_i, // srq enable
	input wire logic status_query_i, // query
	input wire logic serial_poll_read_i, // poll
	input wire logic intr_stat_o, // bit 9
	input wire logic srq_stat_o, // bit 6
	input wire logic srq_o // srq line
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	sequence s_query;
		status_query_i && intr_stat_o;
	endsequence
	sequence s_poll;
		serial_poll_read_i && srq_stat_o;
	endsequence
	a_query_clears: assert property (s_query |=> !intr_stat_o)
		else $error("bit 9 kept after query");
	a_poll_clears: assert property (s_poll |=> !srq_stat_o)
		else $error("bit 6 kept after poll");
	a_intr_cause: assert property ($rose(intr_stat_o) |-> $past(irq_o) && $past(sys_sense_i))
		else $error("bit 9 set without irq");
	a_rearm_gate: assert property ($rose(intr_stat_o) |-> !$past(srq_stat_o))
		else $error("irq taken before bit 6 cleared");
	a_bit_holds: assert property (intr_stat_o && !status_query_i |=> intr_stat_o)
		else $error("bit 9 dropped alone");
	a_srq_with_intr: assert property ($rose(srq_stat_o) |-> $rose(intr_stat_o))
		else $error("bit 6 without bit 9");
	a_srq_needs_en: assert property ($rose(srq_o) |-> $past(rqs_en_i) && srq_stat_o)
		else $error("srq line without enable");
	// no capture without a trigger
	a_capture_hold: assert property (!$past(int_first_trig_i) && !first_src_ext_i
		&& !$past(first_src_ext_i, 4) |-> $stable(capture_o))
		else $error("capture changed untriggered");
endmodule : dinirq_props
bind dinirq_top dinirq_props dinirq_props_inst (.*);

// File: verification/test_digital_input_interrupt_logic.sv
`timescale 1ns/10ps
module test_digital_input_interrupt_logic;
	import dinirq_pkg::*;
	logic clock_i = 0, rstn_i = 0, rd_i = 0, wr_i = 0, ext_i = 1, src_i = 0, svc_en = 0;
	logic [2:0] pl = 0;
	logic [15:0] chan = 0, addr_i = 0, wdata_i = 0, rdata_o, capture_o;
	logic irq_o, refused_o, intr_stat_o, srq_stat_o, srq_o, svc, sq, sp;
	int num_errors = 0, n_compared = 0;
	always #4 clock_i = ~clock_i;
	dinirq_top dinirq_top_inst (.clock_i(clock_i), .rstn_i(rstn_i), .chan_i(chan),
		.first_stage_trigger_input_i(ext_i), .int_first_trig_i(pl[0]), .second_trig_i(pl[1]),
		.self_test_i(pl[2]), .first_src_ext_i(src_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .service_i(svc), .sys_sense_i(1'b1),
		.rqs_en_i(1'b1), .status_query_i(sq), .serial_poll_read_i(sp), .irq_o(irq_o),
		.refused_o(refused_o), .capture_o(capture_o), .intr_stat_o(intr_stat_o),
		.srq_stat_o(srq_stat_o), .srq_o(srq_o));
	dinirq_mainframe dinirq_mainframe_inst (.clock_i(clock_i), .rstn_i(rstn_i), .irq_i(irq_o),
		.srq_i(srq_o), .svc_en_i(svc_en), .wait_i(4'h8), .service_o(svc),
		.status_query_o(sq), .serial_poll_read_o(sp));
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask : chk
	task automatic chb(input logic s, input logic e);
		chk({15'h0000, s}, {15'h0000, e});
	endtask : chb
	task automatic tk(input int n);
		repeat (n) @(negedge clock_i);
	endtask : tk
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [15:0] m, input logic [15:0] e);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		@(negedge clock_i);
		chk(rdata_o & m, e);
	endtask : rd
	task automatic pulse(input int b);
		@(posedge clock_i);
		pl[b] <= 1'b1;
		@(posedge clock_i);
		pl[b] <= 1'b0;
	endtask : pulse
	// channels settle through the synchroniser first
	task automatic trig(input logic [15:0] c);
		@(posedge clock_i) chan <= c;
		tk(3);
		pulse(0);
	endtask : trig
	task automatic end_of_test;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (4) @(posedge clock_i);
		rstn_i <= 1'b1;
		rd(16'h0000, 16'hFFFF, 16'h0000);
		rd(16'h0001, 16'hFFFF, 16'h0000);
		rd(16'h0002, 16'h0001, 16'h0000);
		rd(16'h0007, 16'hFFFF, 16'h0000);
		wr(16'h0000, 16'h0F00);
		wr(16'h0001, 16'h0F0F);
		@(posedge clock_i) chan <= 16'h3F80;
		// selector and enable written apart do not arm
		wr(16'h0003, 16'h0004);
		wr(16'h0003, 16'h0001);
		tk(6);
		chb(irq_o, 1'b0);
		@(posedge clock_i) chan <= 16'h3E80;
		wr(16'h0003, 16'h0005);
		tk(6);
		chb(irq_o, 1'b0);
		@(posedge clock_i) chan <= 16'h3F80;
		tk(6);
		chb(irq_o, 1'b1);
		chb(srq_o, 1'b1);
		chb(intr_stat_o, 1'b1);
		tk(16);
		chb(intr_stat_o | srq_stat_o, 1'b0);
		@(posedge clock_i) svc_en <= 1'b1;
		tk(4);
		chb(irq_o, 1'b0);
		rd(16'h0004, 16'h0003, 16'h0000);
		@(posedge clock_i) svc_en <= 1'b0;
		wr(16'h0002, 16'h0001);
		wr(16'h0003, 16'h0005);
		tk(6);
		chb(irq_o, 1'b0);
		@(posedge clock_i) chan <= 16'h3F81;
		tk(6);
		chb(irq_o, 1'b1);
		// pending flag outlives the condition that set it
		@(posedge clock_i) chan <= 16'h3F80;
		tk(6);
		chb(irq_o, 1'b1);
		wr(16'h0003, 16'h0005);
		tk(3);
		chb(irq_o, 1'b0);
		@(posedge clock_i) chan <= 16'h3F81;
		tk(6);
		chb(irq_o, 1'b1);
		wr(16'h0003, 16'h0006);
		tk(3);
		chb(irq_o, 1'b0);
		wr(16'h0003, 16'h0008);
		wr(16'h0003, 16'h0009);
		trig(16'h1234);
		tk(3);
		chk(capture_o, 16'h1234);
		chb(irq_o, 1'b1);
		wr(16'h0002, 16'h0005);
		tk(1);
		chb(refused_o, 1'b1);
		wr(16'h0003, 16'h000A);
		tk(3);
		chb(irq_o, 1'b0);
		rd(16'h0004, 16'h0008, 16'h0008);
		pulse(1);
		rd(16'h0004, 16'h0008, 16'h0000);
		wr(16'h0002, 16'h0002);
		trig(16'h00AA);
		trig(16'h0055);
		tk(3);
		chk(capture_o, 16'h00AA);
		pulse(1);
		trig(16'h0055);
		tk(3);
		chk(capture_o, 16'h0055);
		wr(16'h0002, 16'h0000);
		@(posedge clock_i) chan <= 16'hC3C3;
		@(posedge clock_i) src_i <= 1'b1;
		tk(3);
		@(posedge clock_i) ext_i <= 1'b0;
		tk(6);
		chk(capture_o, 16'hC3C3);
		@(posedge clock_i) ext_i <= 1'b1;
		tk(6);
		@(posedge clock_i) src_i <= 1'b0;
		pulse(1);
		pulse(2);
		wr(16'h0003, 16'h0009);
		tk(3);
		chb(irq_o, 1'b1);
		tk(20);
		end_of_test();
	end
	initial begin
		#(8 * 4000);
		num_errors++;
		end_of_test();
	end
endmodule : test_digital_input_interrupt_logic
